/* design/segmented_tlv_transfer.sv */
// Segmented TLV transfer command handler with APB register access
//
// Summary of operation
// - Tags are one to three context-specific bytes; lengths one to four bytes.
// - Accept only the permitted primitive and constructed tag ranges.
// - Tag 5C requests the top-level tag list and is never allocated.
// - Length encodings use 81, 82, 83 prefixes by value range.
// - Exchanged length fields use the shortest definite form.
// - Transfer state is held separately per logical channel.
// - First block starts a transfer; next blocks must name the current file.
// - Every block except the final one answers with more data status.
// - Commands changing current file or tag pointer abort incomplete transfers.
// - A good first block sets the tag pointer and aborts prior transfer.
// - Error status leaves tag pointer and offset unchanged.
// - Decode P2 block type bits and short file identifier bits.
// - Retrieve runs only when read access condition is met.
// - Absent object answers referenced data not found.
// - Object held by another application's store answers conditions not satisfied.
// - Tag outside permitted ranges answers incorrect data field parameters.
// - Successful retrieve with remaining data answers 62F1 or 62F2.
// - Next block after full retrieval is refused with 6A86.
// - Tag list includes incomplete stores by other applications.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module segmented_tlv_transfer
  import tlv_xfer_pkg::*;
#(
  parameter int NUM_CH = tlv_xfer_pkg::CHANNELS
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cmdDone,
  output logic [15:0]      statusWord
);
  import tlv_xfer_pkg::*;

  // Tag range check for one to three byte tags
  function automatic logic tagValid(input logic [23:0] t, input logic [1:0] n);
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic       ok;
    b0 = t[23:16];
    b1 = t[15:8];
    b2 = t[7:0];
    ok = 1'b0;
    unique case (n)
      2'd1: ok = (b0 >= 8'h80 && b0 <= 8'h9E) || (b0 >= 8'hA0 && b0 <= 8'hBE);
      2'd2: ok = (b0 == 8'h9F || b0 == 8'hBF) && b1 >= 8'h1F && b1 <= 8'h7F;
      2'd3: ok = (b0 == 8'h9F || b0 == 8'hBF) && b1 >= 8'h81 && b2 <= 8'h7F;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Shortest definite length encoding, left aligned, with byte count
  function automatic logic [34:0] derLen(input logic [23:0] v);
    logic [34:0] r;
    r = '0;
    if (v <= LEN_MAX1) begin
      r = {3'd1, v[7:0], 24'h00_0000};
    end else if (v <= LEN_MAX2) begin
      r = {3'd2, LEN_PFX1, v[7:0], 16'h0000};
    end else if (v <= LEN_MAX3) begin
      r = {3'd3, LEN_PFX2, v[15:0], 8'h00};
    end else begin
      r = {3'd4, LEN_PFX3, v};
    end
    return r;
  endfunction

  logic [31:0]  cmdReg;
  logic [23:0]  tagReg;
  logic [23:0]  objLen;
  logic [23:0]  blkLen;
  logic [34:0]  lenEnc;
  chan_ctx_type ctx [NUM_CH];

  logic         apbWrite;
  logic         apbRead;
  logic         go;
  logic [CH_W-1:0] ch;
  logic [7:0]   p2;
  blk_type      blk;
  logic [1:0]   tagBytes;
  logic         isRetr;
  logic [15:0]  next_sw;
  logic         next_ok;
  chan_ctx_type cur;
  chan_ctx_type next_ctx;
  logic [23:0]  remain;

  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && penable && !pwrite;
  assign go       = apbWrite && paddr == ADDR_CMD && pwdata[CMD_GO_BIT] && pstrb == 4'hF;
  assign ch       = pwdata[CMD_CH_LSB +: CH_W];
  assign p2       = pwdata[7:0];
  assign blk      = blk_type'(p2[7:6]);
  assign tagBytes = pwdata[CMD_TAGLEN_LSB +: 2];
  assign isRetr   = pwdata[CMD_RETR_BIT];
  assign cur      = ctx[ch];
  assign remain   = cur.total - cur.offset;

  // Command evaluation and per-channel context update
  always_comb begin
    next_sw  = SW_OK;
    next_ok  = 1'b1;
    next_ctx = cur;
    if (pwdata[CMD_MODFILE_BIT]) begin
      next_ctx.active = 1'b0;
      next_ctx.done   = 1'b0;
    end else if (blk == BLK_RSV || (blk != BLK_FIRST && p2[4:0] != 5'd0)) begin
      next_sw = SW_BADP1P2;
      next_ok = 1'b0;
    end else if (isRetr && !pwdata[CMD_READOK_BIT]) begin
      next_sw = SW_DENIED;
      next_ok = 1'b0;
    end else if (blk == BLK_FIRST) begin
      if (tagReg[23:16] == TAG_LIST && tagBytes == 2'd1) begin
        // Tag list length is supplied by software, including pending stores
        next_ctx.tag = tagReg;
      end else if (!tagValid(tagReg, tagBytes)) begin
        next_sw = SW_BADDATA;
        next_ok = 1'b0;
      end else if (isRetr && !pwdata[CMD_PRESENT_BIT]) begin
        next_sw = SW_NOTFOUND;
        next_ok = 1'b0;
      end else if (pwdata[CMD_LOCKED_BIT]) begin
        next_sw = SW_COND;
        next_ok = 1'b0;
      end
      if (next_ok) begin
        // Fresh context aborts any earlier transfer
        next_ctx.tag      = tagReg;
        next_ctx.retrieve = isRetr;
        next_ctx.total    = objLen;
        next_ctx.offset   = (blkLen > objLen) ? objLen : blkLen;
        next_ctx.lastBlk  = next_ctx.offset;
        next_ctx.active   = next_ctx.offset < objLen;
        next_ctx.done     = !next_ctx.active;
      end
    end else if (blk == BLK_NEXT) begin
      if (cur.done || !cur.active) begin
        next_sw = SW_BADP1P2;
        next_ok = 1'b0;
      end else begin
        next_ctx.lastBlk = (blkLen > remain) ? remain : blkLen;
        next_ctx.offset  = cur.offset + next_ctx.lastBlk;
        next_ctx.active  = next_ctx.offset < cur.total;
        next_ctx.done    = !next_ctx.active;
      end
    end else begin
      if (!cur.okPrev || cur.lastBlk == cur.offset) begin
        next_sw = SW_BADP1P2;
        next_ok = 1'b0;
      end
    end
    if (next_ok && next_ctx.active) begin
      if (pwdata[CMD_PROACT_BIT]) begin
        next_sw = isRetr ? SW_MOREPEND : SW_MOREPEND_S;
      end else begin
        next_sw = isRetr ? SW_MORE_AVL : SW_MORE_EXP;
      end
    end
    next_ctx.okPrev = next_ok;
    if (!next_ok) begin
      next_ctx        = cur;
      next_ctx.okPrev = 1'b0;
    end
  end

  // Per-channel contexts
  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          ctx[i] <= '0;
        end else if (go && ch == CH_W'(i)) begin
          ctx[i] <= next_ctx;
        end
      end
    end
  endgenerate

  // Software written registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmdReg <= 32'h0000_0000;
      tagReg <= 24'h00_0000;
      objLen <= 24'h00_0000;
      blkLen <= 24'h00_0000;
    end else if (apbWrite && pstrb == 4'hF) begin
      unique case (paddr)
        ADDR_CMD:    cmdReg <= pwdata & 32'h7FFF_FFFF;
        ADDR_TAG:    tagReg <= pwdata[23:0];
        ADDR_OBJLEN: objLen <= pwdata[23:0];
        ADDR_BLKLEN: blkLen <= pwdata[23:0];
        default:     cmdReg <= cmdReg;
      endcase
    end
  end

  // Command result
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      statusWord <= 16'h0000;
      cmdDone    <= 1'b0;
      lenEnc     <= '0;
    end else begin
      cmdDone <= go;
      if (go) begin
        statusWord <= next_sw;
        lenEnc     <= derLen(next_ctx.total);
      end
    end
  end

  // APB slave, no wait states
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          ADDR_CMD:    prdata <= cmdReg;
          ADDR_TAG:    prdata <= {8'h00, tagReg};
          ADDR_OBJLEN: prdata <= {8'h00, objLen};
          ADDR_BLKLEN: prdata <= {8'h00, blkLen};
          ADDR_STATUS: prdata <= {16'h0000, statusWord};
          ADDR_OFFSET: prdata <= {8'h00, ctx[pwdata[CMD_CH_LSB +: CH_W]].offset};
          ADDR_CURTAG: prdata <= {5'd0, ctx[0].active, ctx[0].done, ctx[0].okPrev, ctx[0].tag};
          ADDR_LENENC: prdata <= lenEnc[31:0];
          default:     pslverr <= 1'b1;
        endcase
      end
    end
  end

  badp2_resp_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && pwdata[7:6] == 2'b11 && !pwdata[CMD_MODFILE_BIT] |=> statusWord == SW_BADP1P2)
    else $error("reserved block type not refused");
  err_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && !next_ok |=> ctx[$past(ch)].offset == $past(cur.offset) && ctx[$past(ch)].tag == $past(cur.tag)
    && ctx[$past(ch)].active == $past(cur.active) && ctx[$past(ch)].total == $past(cur.total))
    else $error("context moved on error");
  done_refuse_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && blk == BLK_NEXT && cur.done && !pwdata[CMD_MODFILE_BIT] && !pwdata[CMD_READOK_BIT] == 1'b0
    |=> statusWord == SW_BADP1P2)
    else $error("next block after completion accepted");
  more_sw_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && next_ok && next_ctx.active && isRetr && !pwdata[CMD_PROACT_BIT] |=> statusWord == SW_MORE_AVL)
    else $error("missing more data status");
  abort_mod_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && pwdata[CMD_MODFILE_BIT] |=> !ctx[$past(ch)].active)
    else $error("file change did not abort");
  read_deny_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && isRetr && !pwdata[CMD_READOK_BIT] && !pwdata[CMD_MODFILE_BIT] && pwdata[7:6] != 2'b11
    && (pwdata[7] || pwdata[4:0] == 5'd0) |=> statusWord == SW_DENIED)
    else $error("read access not enforced");
  done_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmdDone |=> !cmdDone || $past(go))
    else $error("done pulse stuck");
  apb_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    psel && !penable |=> pready)
    else $error("apb answer late");
  first_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && blk == BLK_FIRST && next_ok && !pwdata[CMD_MODFILE_BIT] |=> ctx[$past(ch)].tag == $past(tagReg))
    else $error("first block did not set tag pointer");

  // Status word for the more data and success outcomes, and its hold between commands
  more_exp_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && next_ok && next_ctx.active && !isRetr && !pwdata[CMD_PROACT_BIT] |=> statusWord == SW_MORE_EXP)
    else $error("missing more data expected status");

  more_pend_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && next_ok && next_ctx.active && isRetr && pwdata[CMD_PROACT_BIT] |=> statusWord == SW_MOREPEND)
    else $error("missing more data with pending command status");

  proact_exp_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && next_ok && next_ctx.active && !isRetr && pwdata[CMD_PROACT_BIT] |=> statusWord == SW_MOREPEND_S)
    else $error("missing more expected with pending command status");

  last_ok_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && next_ok && !next_ctx.active |=> statusWord == SW_OK)
    else $error("final block not answered with success");

  status_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !go |=> statusWord == $past(statusWord))
    else $error("status word changed without a command");

  // First block refusals
  not_found_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && blk == BLK_FIRST && !pwdata[CMD_MODFILE_BIT] && isRetr && pwdata[CMD_READOK_BIT]
    && tagValid(tagReg, tagBytes) && !pwdata[CMD_PRESENT_BIT] |=> statusWord == SW_NOTFOUND)
    else $error("absent object not reported");

  locked_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && blk == BLK_FIRST && !pwdata[CMD_MODFILE_BIT] && (!isRetr || pwdata[CMD_READOK_BIT])
    && tagValid(tagReg, tagBytes) && (!isRetr || pwdata[CMD_PRESENT_BIT]) && pwdata[CMD_LOCKED_BIT]
    |=> statusWord == SW_COND)
    else $error("object held elsewhere not refused");

  bad_tag_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && blk == BLK_FIRST && !pwdata[CMD_MODFILE_BIT] && (!isRetr || pwdata[CMD_READOK_BIT])
    && !tagValid(tagReg, tagBytes) && !(tagReg[23:16] == TAG_LIST && tagBytes == 2'd1)
    |=> statusWord == SW_BADDATA)
    else $error("tag outside ranges accepted");

  tag_list_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && blk == BLK_FIRST && !pwdata[CMD_MODFILE_BIT] && (!isRetr || pwdata[CMD_READOK_BIT])
    && tagReg[23:16] == TAG_LIST && tagBytes == 2'd1 |=> statusWord != SW_BADDATA)
    else $error("tag list request refused");

  // Block type decoding and context movement
  sfi_next_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && !pwdata[CMD_MODFILE_BIT] && !p2[7] && p2[4:0] != 5'd0 |=> statusWord == SW_BADP1P2)
    else $error("file identifier on later block accepted");

  rsv_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && blk == BLK_RSV && !pwdata[CMD_MODFILE_BIT]
    |=> ctx[$past(ch)].offset == $past(cur.offset) && ctx[$past(ch)].tag == $past(cur.tag))
    else $error("reserved block type moved the context");

  retx_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && blk == BLK_RETX && next_ok && !pwdata[CMD_MODFILE_BIT]
    |=> ctx[$past(ch)].offset == $past(cur.offset))
    else $error("retransmit moved the offset");

  next_adv_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && blk == BLK_NEXT && next_ok && !pwdata[CMD_MODFILE_BIT]
    |=> ctx[$past(ch)].offset > $past(cur.offset) || $past(blkLen) == 24'h00_0000)
    else $error("next block did not advance");

  first_total_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && blk == BLK_FIRST && next_ok && !pwdata[CMD_MODFILE_BIT] |=> ctx[$past(ch)].total == $past(objLen))
    else $error("first block did not restart the object");

  done_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && blk == BLK_FIRST && next_ok && !pwdata[CMD_MODFILE_BIT] && next_ctx.active
    |=> !ctx[$past(ch)].done)
    else $error("first block left an old completion");

  other_ch_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && ch != '0 |=> ctx[0] == $past(ctx[0]))
    else $error("command touched another channel");

  mod_status_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && pwdata[CMD_MODFILE_BIT] |=> statusWord == SW_OK)
    else $error("file change not answered with success");

  mod_done_a: assert property (@(posedge clk) disable iff (!rst_b)
    go && pwdata[CMD_MODFILE_BIT] |=> !ctx[$past(ch)].done)
    else $error("file change left a completion");

  // Length encoding is always the shortest form
  len_pfx_a: assert property (@(posedge clk) disable iff (!rst_b)
    lenEnc[34:32] == 3'd1 |-> !lenEnc[31])
    else $error("single byte length above range");

  len_two_a: assert property (@(posedge clk) disable iff (!rst_b)
    lenEnc[34:32] == 3'd2 |-> lenEnc[31:24] == LEN_PFX1 && lenEnc[23])
    else $error("two byte length not shortest");

  len_wide_a: assert property (@(posedge clk) disable iff (!rst_b)
    lenEnc[34:32] > 3'd2 |-> lenEnc[23:16] != 8'h00)
    else $error("wide length not shortest");

  cov_first_c: cover property (@(posedge clk) go && blk == BLK_FIRST && next_ok);
  cov_list_c:  cover property (@(posedge clk) go && blk == BLK_FIRST && tagReg[23:16] == TAG_LIST);
  cov_next_c:  cover property (@(posedge clk) go && blk == BLK_NEXT && next_ok && next_ctx.done);
  cov_retx_c:  cover property (@(posedge clk) go && blk == BLK_RETX && next_ok);
  cov_err_c:   cover property (@(posedge clk) go && !next_ok);
endmodule
`default_nettype wire

/* design/tlv_xfer_pkg.sv */
// Package for the segmented TLV transfer command handler
package tlv_xfer_pkg;
  localparam int CHANNELS = 4;
  localparam int CH_W = 2;
  localparam int OBJ_LEN_W = 24;
  localparam int TAG_W = 24;

  // Register byte addresses
  localparam logic [11:0] ADDR_CMD     = 12'h000;
  localparam logic [11:0] ADDR_TAG     = 12'h004;
  localparam logic [11:0] ADDR_OBJLEN  = 12'h008;
  localparam logic [11:0] ADDR_BLKLEN  = 12'h00C;
  localparam logic [11:0] ADDR_STATUS  = 12'h010;
  localparam logic [11:0] ADDR_OFFSET  = 12'h014;
  localparam logic [11:0] ADDR_CURTAG  = 12'h018;
  localparam logic [11:0] ADDR_LENENC  = 12'h01C;

  // Command register fields
  localparam int CMD_GO_BIT      = 31;
  localparam int CMD_RETR_BIT    = 30;
  localparam int CMD_READOK_BIT  = 29;
  localparam int CMD_PRESENT_BIT = 28;
  localparam int CMD_LOCKED_BIT  = 27;
  localparam int CMD_MODFILE_BIT = 26;
  localparam int CMD_PROACT_BIT  = 25;
  localparam int CMD_TAGLEN_LSB  = 16;
  localparam int CMD_CH_LSB      = 8;

  // Status words
  localparam logic [15:0] SW_OK        = 16'h9000;
  localparam logic [15:0] SW_MORE_AVL  = 16'h62F1;
  localparam logic [15:0] SW_MORE_EXP  = 16'h63F1;
  localparam logic [15:0] SW_MORE_PRO  = 16'h0001;
  localparam logic [15:0] SW_NOTFOUND  = 16'h6A88;
  localparam logic [15:0] SW_COND      = 16'h6985;
  localparam logic [15:0] SW_BADDATA   = 16'h6A80;
  localparam logic [15:0] SW_BADP1P2   = 16'h6A86;
  localparam logic [15:0] SW_DENIED    = 16'h6982;
  localparam logic [15:0] SW_MOREPEND  = 16'h62F2;
  localparam logic [15:0] SW_MOREPEND_S = 16'h63F2;

  localparam logic [7:0] TAG_LIST     = 8'h5C;
  localparam logic [7:0] LEN_PFX1     = 8'h81;
  localparam logic [7:0] LEN_PFX2     = 8'h82;
  localparam logic [7:0] LEN_PFX3     = 8'h83;
  localparam logic [23:0] LEN_MAX1    = 24'h00_007F;
  localparam logic [23:0] LEN_MAX2    = 24'h00_00FF;
  localparam logic [23:0] LEN_MAX3    = 24'h00_FFFF;

  typedef enum logic [1:0] {
    BLK_FIRST = 2'b10,
    BLK_NEXT  = 2'b00,
    BLK_RETX  = 2'b01,
    BLK_RSV   = 2'b11
  } blk_type;

  typedef struct packed {
    logic                 active;
    logic                 done;
    logic                 retrieve;
    logic [TAG_W-1:0]     tag;
    logic [OBJ_LEN_W-1:0] total;
    logic [OBJ_LEN_W-1:0] offset;
    logic [OBJ_LEN_W-1:0] lastBlk;
    logic                 okPrev;
  } chan_ctx_type;

  typedef struct packed {
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } apb_rsp_type;
endpackage

/* verif/terminal_model.sv */
// Terminal-side APB master that issues command words to the card
`timescale 1ns/10ps
`default_nettype none
module terminal_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
  end

  // Released address and data lines show the inverse of the last value
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the segmented TLV transfer handler
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tlv_xfer_pkg::*;
  localparam logic [6:0]  OK    = 7'b1111000;
  localparam logic [15:0] NOCHK = 16'hFFFF;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmdDone;
  logic [15:0] statusWord;
  int          failures;
  int          check_count;

  terminal_model term_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  segmented_tlv_transfer dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmdDone(cmdDone), .statusWord(statusWord));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    term_u.xfer(1'b0, a, d, r, e);
    cmp(r, exp);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    term_u.xfer(1'b1, a, d, r, e);
  endtask

  task automatic load(input logic [23:0] tag, input logic [23:0] olen, input logic [23:0] blen);
    wr(ADDR_TAG, {8'h00, tag});
    wr(ADDR_OBJLEN, {8'h00, olen});
    wr(ADDR_BLKLEN, {8'h00, blen});
  endtask

  // Issues one command word, waits for its completion pulse, judges the status
  task automatic run(input logic [7:0] p2, input logic [1:0] ch, input logic [1:0] tc,
                     input logic [6:0] fl, input logic [15:0] exp);
    int n;
    wr(ADDR_CMD, {fl, 7'h00, tc, 6'h00, ch, p2});
    n = 0;
    #1;
    while (cmdDone !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp({31'h0, cmdDone}, 32'h1);
    if (exp !== NOCHK) begin
      cmp({16'h0, statusWord}, {16'h0, exp});
    end
  endtask

  task automatic t_segment();
    load(24'h80_0000, 24'h00_000A, 24'h00_0004);
    run(8'h80, 2'd0, 2'd1, OK, SW_MORE_AVL);
    rd(ADDR_OFFSET, 32'h0, 32'h0000_0004);
    run(8'h00, 2'd0, 2'd1, OK, SW_MORE_AVL);
    run(8'h40, 2'd0, 2'd1, OK, SW_MORE_AVL);
    rd(ADDR_OFFSET, 32'h0, 32'h0000_0008);
    run(8'h00, 2'd0, 2'd1, OK, SW_OK);
    run(8'h00, 2'd0, 2'd1, OK, SW_BADP1P2);
    $display("Test segment done");
  endtask

  task automatic t_errors();
    logic [7:0]  p2s [5] = '{8'h80, 8'h80, 8'h80, 8'hC0, 8'h05};
    logic [6:0]  fls [5] = '{7'b1101000, 7'b1110000, 7'b1111100, OK, OK};
    logic [15:0] sws [5] = '{SW_DENIED, SW_NOTFOUND, SW_COND, SW_BADP1P2, SW_BADP1P2};
    logic [31:0] r;
    logic        e;
    load(24'h81_0000, 24'h00_000A, 24'h00_0004);
    run(8'h80, 2'd0, 2'd1, OK, SW_MORE_AVL);
    for (int i = 0; i < 5; i++) begin
      run(p2s[i], 2'd0, 2'd1, fls[i], sws[i]);
      rd(ADDR_OFFSET, 32'h0, 32'h0000_0004);
    end
    run(8'h00, 2'd0, 2'd1, OK, SW_MORE_AVL);
    run(8'h40, 2'd3, 2'd1, OK, SW_BADP1P2);
    term_u.xfer(1'b0, 12'h020, 32'h0, r, e);
    cmp({31'h0, e}, 32'h1);
    cmp(r, 32'h0);
    $display("Test errors done");
  endtask

  task automatic t_tags();
    logic [23:0] tgs [11] = '{24'h80_0000, 24'h9E_0000, 24'h9F_1F00, 24'h9F_1E00, 24'h9F_8100,
      24'h9F_8180, 24'hBF_7F00, 24'hA0_0000, 24'h5F_0000, 24'h9F_0000, 24'h5C_0000};
    logic [1:0]  tcs [11] = '{1, 1, 2, 2, 3, 3, 2, 1, 1, 1, 1};
    logic [15:0] sws [11] = '{SW_OK, SW_OK, SW_OK, SW_BADDATA, SW_OK, SW_BADDATA, SW_OK, SW_OK,
      SW_BADDATA, SW_BADDATA, SW_OK};
    for (int i = 0; i < 11; i++) begin
      load(tgs[i], 24'h00_0002, 24'h00_0004);
      run(8'h80, 2'd0, tcs[i], OK, sws[i]);
    end
    $display("Test tags done");
  endtask

  task automatic t_lenenc();
    logic [23:0] ols [6] = '{24'h00_007F, 24'h00_0080, 24'h00_00FF, 24'h00_0100, 24'h01_0000,
      24'hFF_FFFF};
    logic [31:0] enc [6] = '{32'h7F00_0000, 32'h8180_0000, 32'h81FF_0000, 32'h8201_0000,
      32'h8301_0000, 32'h83FF_FFFF};
    for (int i = 0; i < 6; i++) begin
      load(24'h85_0000, ols[i], ols[i]);
      run(8'h80, 2'd0, 2'd1, OK, SW_OK);
      rd(ADDR_LENENC, 32'h0, enc[i]);
    end
    $display("Test length done");
  endtask

  task automatic t_channels();
    load(24'h82_0000, 24'h00_000A, 24'h00_0004);
    run(8'h80, 2'd1, 2'd1, OK, SW_MORE_AVL);
    load(24'h83_0000, 24'h00_0006, 24'h00_0004);
    run(8'h80, 2'd2, 2'd1, OK | 7'b0000001, SW_MOREPEND);
    rd(ADDR_STATUS, 32'h0, {16'h0, SW_MOREPEND});
    run(8'h00, 2'd1, 2'd1, OK, SW_MORE_AVL);
    rd(ADDR_OFFSET, 32'h0000_0100, 32'h0000_0008);
    run(8'h00, 2'd2, 2'd1, OK, SW_OK);
    $display("Test channels done");
  endtask

  task automatic t_abort();
    load(24'h84_0000, 24'h00_000A, 24'h00_0004);
    run(8'h80, 2'd0, 2'd1, OK, SW_MORE_AVL);
    run(8'h00, 2'd0, 2'd1, OK, SW_MORE_AVL);
    run(8'h80, 2'd0, 2'd1, OK, SW_MORE_AVL);
    rd(ADDR_OFFSET, 32'h0, 32'h0000_0004);
    run(8'h00, 2'd0, 2'd1, 7'b1000010, NOCHK);
    run(8'h00, 2'd0, 2'd1, OK, SW_BADP1P2);
    $display("Test abort done");
  endtask

  initial begin
    rst_b = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    cmp({16'h0, statusWord}, 32'h0);
    t_segment();
    t_errors();
    t_tags();
    t_lenenc();
    t_channels();
    t_abort();
    finish_test();
  end

  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
